// file: design/pld_test_pkg.sv
// Constants shared by the preload and configuration logic.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package pld_test_pkg;

	// ==========================================================
	// Sizes and timing
	localparam int NUM_CELLS = 10;
	localparam int SIG_WIDTH = 64;
	localparam int CLK_MHZ = 100;
	localparam int POR_TIME_US = 45;
	localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_SECURE = 8'h04;
	localparam logic [7:0] ADDR_SIG_LO = 8'h08;
	localparam logic [7:0] ADDR_SIG_HI = 8'h0C;
	localparam logic [7:0] ADDR_ARRAY = 8'h10;
	localparam logic [7:0] ADDR_ERASE = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ==========================================================
	// Field positions and reset values
	localparam int SECURE_BIT = 0;
	localparam int ERASE_BIT = 0;
	localparam int STAT_PRELOAD_BIT = 16;
	localparam int STAT_POR_BIT = 17;
	localparam logic [31:0] WORD_ERASED = 32'h0000_0000;

	// ==========================================================
	// Macrocell mode, high select bit first.
	typedef enum logic [1:0] {
		MODE_REG_LOW = 2'b00,
		MODE_REG_HIGH = 2'b01,
		MODE_COMB_LOW = 2'b10,
		MODE_COMB_HIGH = 2'b11
	} cell_mode_e;

endpackage

// file: design/sync_two_ff.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a clock far slower than pclk.
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	// ==========================================================
	// First stage feeds only the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule // sync_two_ff

// file: design/por_timer.sv
// Power-up reset timer: done rises a fixed count after reset release.
// Assumes presetn stands for supply becoming valid.
module por_timer #(
	parameter int CYCLES = 4500
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Status
	output logic done
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_ff;

	if (CYCLES < 1) begin : g_bad_cycles
		$error("por_timer: CYCLES must be at least 1");
	end

	// ==========================================================
	// Count up once, then hold done high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= '0;
			done <= 1'b0;
		end else if (!done) begin
			count_ff <= count_ff + 1'b1;
			done <= (count_ff == CW'(CYCLES - 1));
		end
	end

endmodule // por_timer

// file: design/preload_chain.sv
// Macrocell registers, their serial preload chain and an APB register file.
// Assumes preload pins come from outside the pclk domain; logic_func,
// cell_oe_term and logic_clock_en come from the array on pclk.
//
// Implementation choices: the APB register port and the register addresses.

// Operation
// RULE_01: Once secured, array and configuration writes and readback are refused.
// RULE_02: Security bit is cleared only by bulk erase of everything.
// RULE_03: A 64-bit user signature is held in rewritable storage.
// RULE_04: Signature contents drive no logic or output.
// RULE_05: Signature reads always work, secured or not.
// RULE_06: Programmer erases in bulk before every programming pass.
// RULE_07: Bulk erase clears array, configuration, security bit and signature.
// RULE_08: Tester waits 45 us power-up reset before preload.
// RULE_09: Raised mode select routes registers into the serial chain.
// RULE_10: Chain holds one bit per registered cell; combinatorial cells bypassed.
// RULE_11: Chain shifts on the shift clock rising edge, sampling serial input.
// RULE_12: Data enters lowest registered cell and moves to higher cells.
// RULE_13: Old contents shift upward out of the serial output.
// RULE_14: Serial low is 0, high is 1; pins show register inverted.
// RULE_15: Readback shows register state whatever the output enables.
// RULE_16: Preload anywhere in a test; clocking resumes from loaded state.
// RULE_17: Tester loads state, applies inputs, clocks once, checks.
// RULE_18: Serial output may chain into the next device's input.
// RULE_19: Two select bits per cell pick registered/combinatorial and polarity.
// RULE_20: All macrocell registers clear low at power-up.
// RULE_21: Registered cells capture on the clock edge; polarity before register.
// RULE_22: Registered cells feed back register; combinatorial feed back pin.
// RULE_23: Dropping mode select resumes normal operation from loaded state.
module preload_chain #(
	parameter int N = pld_test_pkg::NUM_CELLS,
	parameter int POR_CYC = pld_test_pkg::POR_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Preload pins
	input wire logic preload_mode_select,
	input wire logic serial_preload_in,
	input wire logic preload_shift_clock,
	output logic serial_preload_out_o,
	output logic serial_preload_out_oe,
	// Macrocells
	input wire logic logic_clock_en,
	input wire logic [N-1:0] logic_func,
	input wire logic [N-1:0] cell_oe_term,
	input wire logic [N-1:0] cell_pin_in,
	output logic [N-1:0] cell_pin_o,
	output logic [N-1:0] cell_pin_oe,
	output logic [N-1:0] cell_feedback
);

	import pld_test_pkg::*;

	// Status bits and configuration pairs must fit one 32-bit word.
	if (N < 1 || N > 16) begin : g_bad_n
		$error("preload_chain: N must be 1 to 16");
	end

	logic [N+2:0] sync_bus;
	logic mode_s, ser_in_s, shift_clk_s, shift_clk_d_ff, por_done;
	logic [N-1:0] pin_s, q_ff, is_reg, act_high;
	logic [N:0] carry;
	logic [2*N-1:0] config_ff;
	logic secure_ff;
	logic [SIG_WIDTH-1:0] sig_ff;
	logic [31:0] array_ff, nxt_rdata;
	logic ser_out_ff, preload_act, shift_pulse, wr_en, erase_req, nxt_err;
	logic [31:0] rdata_ff;
	logic err_ff;

	// ==========================================================
	// Pin synchronisers and power-up timer
	sync_two_ff #(.WIDTH(N + 3)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({cell_pin_in, preload_shift_clock, serial_preload_in, preload_mode_select}),
		.sync_out(sync_bus)
	);
	assign mode_s = sync_bus[0];
	assign ser_in_s = sync_bus[1];
	assign shift_clk_s = sync_bus[2];
	assign pin_s = sync_bus[N+2:3];

	por_timer #(.CYCLES(POR_CYC)) u_por (
		.pclk(pclk),
		.presetn(presetn),
		.done(por_done)
	);

	// ==========================================================
	// Shift clock edge detect on the synchronised copy.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_clk_d_ff <= 1'b0;
		end else begin
			shift_clk_d_ff <= shift_clk_s;
		end
	end

	// RULE_09 mode entry gating
	// Preload is active only after power-up reset and while mode is high.
	assign preload_act = mode_s && por_done;
	// RULE_11 shift on rising edge
	assign shift_pulse = preload_act && shift_clk_s && !shift_clk_d_ff;

	// ==========================================================
	// Per-cell mode decode and chain routing.
	assign carry[0] = ser_in_s;
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cell
			cell_mode_e mode;
			// RULE_19 select decode
			assign mode = cell_mode_e'(config_ff[2*g+1 -: 2]);
			assign is_reg[g] = (mode == MODE_REG_LOW) || (mode == MODE_REG_HIGH);
			assign act_high[g] = (mode == MODE_REG_HIGH) || (mode == MODE_COMB_HIGH);
			// RULE_10 bypass combinatorial cells
			assign carry[g+1] = is_reg[g] ? q_ff[g] : carry[g];

			// RULE_20 cleared at power-up
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					q_ff[g] <= 1'b0;
				end else if (preload_act) begin
					// RULE_12 lowest cell first, upward
					if (shift_pulse && is_reg[g]) begin
						q_ff[g] <= carry[g];
					end
				end else if (logic_clock_en) begin
					// RULE_21 polarity ahead of register
					// RULE_23 resume from loaded state
					// RULE_16 clocking resumes after preload
					q_ff[g] <= act_high[g] ? !logic_func[g] : logic_func[g];
				end
			end

			// Pin drive and feedback are registered copies.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cell_pin_o[g] <= 1'b0;
					cell_pin_oe[g] <= 1'b0;
					cell_feedback[g] <= 1'b0;
				end else begin
					// RULE_14 pin shows register inverted
					cell_pin_o[g] <= is_reg[g] ? !q_ff[g] : (act_high[g] ? logic_func[g] : !logic_func[g]);
					cell_pin_oe[g] <= cell_oe_term[g] && !preload_act;
					// RULE_22 feedback source
					cell_feedback[g] <= is_reg[g] ? q_ff[g] : pin_s[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Serial output: open drain, pulls low for a 0 during preload.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_out_ff <= 1'b1;
		end else begin
			// RULE_13 top registered bit leaves first
			ser_out_ff <= carry[N];
		end
	end
	assign serial_preload_out_o = 1'b0;
	// RULE_15 readback independent of cell enables
	assign serial_preload_out_oe = preload_act && !ser_out_ff;

	// ==========================================================
	// APB decode: no wait states, answer built in the setup cycle.
	assign pready = psel && penable;
	assign wr_en = psel && penable && pwrite;
	assign erase_req = wr_en && (paddr == ADDR_ERASE) && pwdata[ERASE_BIT];
	assign prdata = rdata_ff;
	assign pslverr = pready && err_ff;

	// Read mux and address check for the coming access phase.
	always_comb begin
		nxt_rdata = WORD_ERASED;
		nxt_err = 1'b0;
		unique case (paddr)
			// RULE_01 readback refused when secured
			ADDR_CONFIG: nxt_rdata = secure_ff ? WORD_ERASED : 32'(config_ff);
			ADDR_ARRAY: nxt_rdata = secure_ff ? WORD_ERASED : array_ff;
			ADDR_SECURE: nxt_rdata = 32'(secure_ff);
			// RULE_05 signature always readable
			ADDR_SIG_LO: nxt_rdata = sig_ff[31:0];
			ADDR_SIG_HI: nxt_rdata = sig_ff[63:32];
			ADDR_ERASE: nxt_rdata = WORD_ERASED;
			ADDR_STATUS: begin
				nxt_rdata[N-1:0] = q_ff;
				nxt_rdata[STAT_PRELOAD_BIT] = preload_act;
				nxt_rdata[STAT_POR_BIT] = por_done;
			end
			default: nxt_err = 1'b1;
		endcase
	end

	// Capture the answer in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= WORD_ERASED;
			err_ff <= 1'b0;
		end else if (psel && !penable) begin
			rdata_ff <= pwrite ? WORD_ERASED : nxt_rdata;
			err_ff <= nxt_err;
		end
	end

	// ==========================================================
	// Programmable cells: configuration, array word and signature.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_ff <= '0;
			array_ff <= WORD_ERASED;
			sig_ff <= '0;
		end else if (erase_req) begin
			// RULE_07 bulk erase clears all cells
			config_ff <= '0;
			array_ff <= WORD_ERASED;
			sig_ff <= '0;
		end else if (wr_en && !secure_ff) begin
			// RULE_01 programming refused when secured
			// RULE_03 user signature storage
			// RULE_04 signature feeds only readback
			unique case (paddr)
				ADDR_CONFIG: config_ff <= pwdata[2*N-1:0];
				ADDR_ARRAY: array_ff <= pwdata;
				ADDR_SIG_LO: sig_ff[31:0] <= pwdata;
				ADDR_SIG_HI: sig_ff[63:32] <= pwdata;
				default: ;
			endcase
		end
	end

	// RULE_02 security cleared only by erase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secure_ff <= 1'b0;
		end else if (erase_req) begin
			secure_ff <= 1'b0;
		end else if (wr_en && paddr == ADDR_SECURE && pwdata[SECURE_BIT]) begin
			secure_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	secure_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
		secure_ff && !erase_req |=> secure_ff)
		else $error("security bit cleared without erase");

	secure_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
		secure_ff && !erase_req |=> $stable(config_ff) && $stable(array_ff))
		else $error("configuration changed while secured");

	secure_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
		psel && !penable && !pwrite && secure_ff && paddr == ADDR_CONFIG |=> rdata_ff == WORD_ERASED)
		else $error("configuration readable while secured");

	sig_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
		psel && !penable && !pwrite && paddr == ADDR_SIG_LO |=> rdata_ff == $past(sig_ff[31:0]))
		else $error("signature readback wrong");

	erase_all_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
		erase_req |=> config_ff == '0 && sig_ff == '0 && !secure_ff && array_ff == WORD_ERASED)
		else $error("bulk erase incomplete");

	no_early_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
		!por_done |-> !preload_act && !serial_preload_out_oe)
		else $error("preload active before power-up reset");

	shift_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
		preload_act && !shift_pulse |=> $stable(q_ff) or !$past(preload_act))
		else $error("chain moved without shift edge");

	shift_first_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
		shift_pulse && is_reg[0] |=> q_ff[0] == $past(ser_in_s))
		else $error("lowest registered cell missed serial input");

	bypass_cell_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
		shift_pulse |=> ((q_ff ^ $past(q_ff)) & ~$past(is_reg)) == '0)
		else $error("combinatorial cell entered chain");

	ser_out_track_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
		preload_act ##1 preload_act |-> serial_preload_out_oe == !$past(carry[N]))
		else $error("serial output does not follow top bit");

	pin_invert_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
		is_reg[0] |=> cell_pin_o[0] == !$past(q_ff[0]))
		else $error("registered pin not inverted");

	fb_source_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
		is_reg[0] |=> cell_feedback[0] == $past(q_ff[0]))
		else $error("registered feedback not taken from register");

	hold_state_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_23
		!preload_act && !logic_clock_en |=> $stable(q_ff))
		else $error("register changed without a clock");

endmodule // preload_chain

// file: bench/prog_model.sv
// Programmer model: drives the preload pins with an 80 ns shift clock.
// Assumes the bench resolves the open-drain serial output with a pull-up.
module prog_model (
	// Preload pins
	output logic preload_mode_select,
	output logic serial_preload_in,
	output logic preload_shift_clock,
	// Serial readback line
	input wire logic serial_preload_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Pins idle with the shift clock held still and mode at the normal level.
	initial begin
		preload_mode_select = 1'h0;
		serial_preload_in = 1'h0;
		preload_shift_clock = 1'h0;
	end

	task automatic mode(input logic m);
		preload_mode_select <= m;
		#53;
	endtask

	task automatic shift(input int k, input logic [15:0] din, output logic [15:0] dout);
		dout = 16'h0;
		#3;
		for (int i = 0; i < k; i++) begin
			serial_preload_in = din[i];
			#20;
			dout[i] = serial_preload_out;
			preload_shift_clock = 1'h1;
			#40;
			preload_shift_clock = 1'h0;
			// Hold time is over, so the line shows the opposite level.
			serial_preload_in = ~din[i];
			#20;
		end
	endtask
endmodule // prog_model

// file: bench/tb.sv
// Bench for the preload chain: APB registers, serial preload and next state.
// Assumes prog_model on the preload pins and pull-ups on open-drain lines.
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin failures++; \
$display("Error %s expected %h seen %h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pld_test_pkg::*;
	// ==========================================
	// Signals
	typedef struct {logic [31:0] e; logic [31:0] m; logic err;} note_s;
	note_s notes[$];
	note_s n;
	int failures = 0;
	int checks_done = 0;
	int regs[$];
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic clk_en = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [63:0] sig;
	logic [31:0] word;
	logic pready;
	logic pslverr;
	logic sdo_o;
	logic sdo_oe;
	logic sdo;
	logic mode;
	logic sdi;
	logic sck;
	logic [19:0] cfg;
	logic [15:0] din;
	logic [15:0] dout;
	logic [NUM_CELLS-1:0] func = '0;
	logic [NUM_CELLS-1:0] oe_term = '0;
	logic [NUM_CELLS-1:0] ext_pin = '0;
	logic [NUM_CELLS-1:0] pin_in;
	logic [NUM_CELLS-1:0] pin_o;
	logic [NUM_CELLS-1:0] pin_oe;
	logic [NUM_CELLS-1:0] fb;
	logic [NUM_CELLS-1:0] regmask;
	logic [NUM_CELLS-1:0] q;
	logic [NUM_CELLS-1:0] fv;
	logic [NUM_CELLS-1:0] cpin;
	logic [7:0] ea[5] = '{ADDR_CONFIG, ADDR_SECURE, ADDR_SIG_LO, ADDR_SIG_HI, ADDR_ARRAY};

	// Open-drain serial line with pull-up, and cell pins as seen outside.
	assign sdo = sdo_oe ? sdo_o : 1'h1;
	assign pin_in = (pin_oe & pin_o) | (~pin_oe & ext_pin);

	preload_chain #(.N(NUM_CELLS), .POR_CYC(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .preload_mode_select(mode), .serial_preload_in(sdi), .preload_shift_clock(sck),
		.serial_preload_out_o(sdo_o), .serial_preload_out_oe(sdo_oe), .logic_clock_en(clk_en),
		.logic_func(func), .cell_oe_term(oe_term), .cell_pin_in(pin_in), .cell_pin_o(pin_o),
		.cell_pin_oe(pin_oe), .cell_feedback(fb));
	prog_model PM (.preload_mode_select(mode), .serial_preload_in(sdi), .preload_shift_clock(sck),
		.serial_preload_out(sdo));

	// ==========================================
	// Clock, bus tasks and result monitor
	initial begin
		forever #5 pclk = ~pclk;
	end

	// One APB transfer; its expected outcome is noted before it starts.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic [31:0] m, input logic err);
		notes.push_back('{e, m, err});
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d, 32'h0, 32'h0, 1'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'h0, a, 32'h0, e, m, 1'h0);
	endtask
	function automatic logic [31:0] stat(input logic [1:0] b, input logic [NUM_CELLS-1:0] v);
		return {14'h0, b, 6'h0, v};
	endfunction

	// Each completed transfer takes the oldest note and compares it.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1) begin
			n = notes.pop_front();
			`CHK("prdata", n.e, prdata & n.m)
			`CHK("pslverr", n.err, pslverr)
		end
	end

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: the run needs a few microseconds.
	initial begin
		#50000;
		failures++;
		results();
	end

	// ==========================================
	// Tests
	initial begin
		void'($urandom(32'hA35F));
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(ADDR_STATUS, stat(2'h0, '0), stat(2'h3, '1));
		repeat (25) @(posedge pclk);
		rd(ADDR_STATUS, stat(2'h2, '0), stat(2'h3, '1));
		$display("test reset done");
		sig = {$urandom, $urandom};
		word = $urandom;
		wr(ADDR_SIG_LO, sig[31:0]);
		wr(ADDR_SIG_HI, sig[63:32]);
		wr(ADDR_ARRAY, word);
		rd(ADDR_SIG_HI, sig[63:32], 32'hFFFFFFFF);
		wr(ADDR_CONFIG, 32'h5);
		wr(ADDR_SECURE, 32'h1);
		wr(ADDR_CONFIG, 32'hFFFFF);
		wr(ADDR_SIG_LO, ~sig[31:0]);
		rd(ADDR_CONFIG, 32'h0, 32'hFFFFFFFF);
		rd(ADDR_ARRAY, 32'h0, 32'hFFFFFFFF);
		rd(ADDR_SIG_LO, sig[31:0], 32'hFFFFFFFF);
		apb(1'h1, 8'h1C, 32'h1, 32'h0, 32'h0, 1'h1);
		wr(ADDR_ERASE, 32'h1);
		foreach (ea[i]) rd(ea[i], 32'h0, 32'hFFFFFFFF);
		wr(ADDR_ARRAY, word);
		rd(ADDR_ARRAY, word, 32'hFFFFFFFF);
		$display("test registers done");
		regmask = '0;
		for (int i = 0; i < NUM_CELLS; i++) begin
			cfg[2*i +: 2] = 2'(i % 4);
			regmask[i] = (i % 4) < 2;
			if (regmask[i]) regs.push_back(i);
		end
		wr(ADDR_CONFIG, {12'h0, cfg});
		rd(ADDR_CONFIG, {12'h0, cfg}, 32'hFFFFFFFF);
		oe_term <= '1;
		q = '0;
		for (int f = 0; f < 2; f++) begin
			din = 16'($urandom);
			PM.mode(1'h1);
			@(posedge pclk);
			rd(ADDR_STATUS, stat(2'h3, q), stat(2'h3, regmask));
			`CHK("pin_oe", '0, pin_oe)
			PM.shift(regs.size(), din, dout);
			for (int j = 0; j < regs.size(); j++) begin
				`CHK("sdo", q[regs[regs.size()-1-j]], dout[j])
				q[regs[regs.size()-1-j]] = din[j];
			end
			@(posedge pclk);
			rd(ADDR_STATUS, stat(2'h3, q), stat(2'h3, regmask));
		end
		$display("test preload done");
		PM.mode(1'h0);
		@(posedge pclk);
		`CHK("pin_oe", '1, pin_oe)
		oe_term <= '0;
		ext_pin <= NUM_CELLS'($urandom);
		fv = NUM_CELLS'($urandom);
		func <= fv;
		repeat (4) @(posedge pclk);
		rd(ADDR_STATUS, stat(2'h2, q), stat(2'h3, regmask));
		clk_en <= 1'h1;
		@(posedge pclk);
		clk_en <= 1'h0;
		for (int i = 0; i < NUM_CELLS; i++) begin
			if (regmask[i]) q[i] = cfg[2*i] ? ~fv[i] : fv[i];
			cpin[i] = cfg[2*i] ? fv[i] : ~fv[i];
		end
		repeat (4) @(posedge pclk);
		rd(ADDR_STATUS, stat(2'h2, q), stat(2'h3, regmask));
		`CHK("pin_o", ~q & regmask, pin_o & regmask)
		`CHK("comb pin", cpin & ~regmask, pin_o & ~regmask)
		`CHK("feedback", (q & regmask) | (ext_pin & ~regmask), fb)
		`CHK("notes left", 0, notes.size())
		$display("test next state done");
		results();
	end
endmodule // tb
